// ### core/sadc_clkdiv.sv
`timescale 1ns/1ps
module sadc_clkdiv
	import sadc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic fast,
	output logic tick
);
	logic [1:0] cnt_ff; // Divide counter
	logic [1:0] lim; // Terminal count

	// Selects the divide ratio
	always_comb begin
		lim = fast ? SADC_DIV_FAST : SADC_DIV_SLOW;
	end

	// Counts CPU clocks while running
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt_ff <= 2'h0;
		end else if (cnt_ff >= lim) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end

	// One-cycle enable at the end of each period
	assign tick = run && (cnt_ff >= lim);
endmodule

// ### core/sadc_pkg.sv
package sadc_pkg;
	// Register byte addresses (printed offsets 0..2 are not multiples of four)
	localparam logic [1:0] SADC_IDX_CSR = 2'h0; // Control/status index
	localparam logic [1:0] SADC_IDX_UPPER = 2'h1; // Upper result index
	localparam logic [1:0] SADC_IDX_LOWER = 2'h2; // Lower result index
	localparam logic [11:0] SADC_ADDR_CSR = {8'h00, SADC_IDX_CSR, 2'h0};
	localparam logic [11:0] SADC_ADDR_UPPER = {8'h00, SADC_IDX_UPPER, 2'h0};
	localparam logic [11:0] SADC_ADDR_LOWER = {8'h00, SADC_IDX_LOWER, 2'h0};
	// Control/status field positions
	localparam int SADC_CSR_DONE_BIT = 7;
	localparam int SADC_CSR_SPEED_BIT = 6;
	localparam int SADC_CSR_EN_BIT = 5;
	localparam int SADC_CSR_SEL_LSB = 0;
	localparam int SADC_CSR_SEL_W = 4;
	// Widths
	localparam int SADC_RES_W = 10;
	localparam int SADC_BIT_CNT_W = 4;
	localparam int SADC_CH_N = 16;
	// Reset values
	localparam logic [7:0] SADC_CSR_RST = 8'h00;
	localparam logic [9:0] SADC_RES_RST = 10'h000;
	// Converter clock divide counts
	localparam logic [1:0] SADC_DIV_SLOW = 2'h3; // CPU clock / 4
	localparam logic [1:0] SADC_DIV_FAST = 2'h1; // CPU clock / 2
	// Successive approximation states
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_SAMPLE = 2'b01,
		SADC_CONVERT = 2'b10
	} sadc_state_t;
endpackage

// ### core/sadc_sar.sv
`timescale 1ns/1ps
module sadc_sar
	import sadc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic restart,
	input wire logic tick,
	input wire logic cmp_high,
	output logic sample,
	output logic [9:0] trial,
	output logic done,
	output logic [9:0] result
);
	sadc_state_t state_ff; // Sequencer state
	logic [9:0] trial_ff; // Approximation register
	logic [3:0] bit_ff; // Bit under test

	// Current trial code drives the analog DAC
	assign trial = trial_ff;
	assign sample = (state_ff == SADC_SAMPLE);

	// Sequencer: sample one tick, then one decision per tick, MSB first
	always_ff @(posedge clk) begin
		if (!rst_n || !run || restart) begin
			state_ff <= SADC_IDLE;
			trial_ff <= SADC_RES_RST;
			bit_ff <= 4'h9;
		end else if (tick) begin
			case (state_ff)
				SADC_IDLE: begin
					state_ff <= SADC_SAMPLE;
				end
				SADC_SAMPLE: begin
					// Start with the MSB set
					trial_ff <= 10'h200;
					bit_ff <= 4'h9;
					state_ff <= SADC_CONVERT;
				end
				SADC_CONVERT: begin
					// Keep bit when input is above trial, then try the next
					trial_ff[bit_ff] <= cmp_high;
					if (bit_ff != 4'h0) begin
						trial_ff[bit_ff - 4'h1] <= 1'b1;
						bit_ff <= bit_ff - 4'h1;
					end else begin
						// Back to back: sample again next tick
						state_ff <= SADC_SAMPLE;
					end
				end
				default: begin
					state_ff <= SADC_IDLE;
				end
			endcase
		end
	end

	// Final code; saturates naturally to all ones or zero
	assign done = rst_n && run && !restart && tick && (state_ff == SADC_CONVERT)
		&& (bit_ff == 4'h0);
	always_comb begin
		result = trial_ff;
		result[0] = cmp_high;
	end
endmodule

// ### core/sadc_top.sv
//
// Contract
// - Ten-bit SAR over sixteen multiplexed inputs
// - Results are monotonic with input
// - Over high reference reads all ones
// - Under low reference reads zero
// - Four-bit selector picks the input
// - Enable starts continuous back-to-back conversion
// - Completion stores result, sets done
// - Upper result read clears done
// - Each conversion overwrites both bytes unlatched
// - Selector write aborts, clears done, restarts
// - Digital pin reads stay working
// - Any control write clears done
// - Enable clear stops; resets disabled
// - Speed bit picks divide four or two
// - Upper holds bits 9:2, lower 1:0
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module sadc_top
	import sadc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmp_high,
	input wire logic [15:0] analog_pin_digital,
	output logic [3:0] input_selector,
	output logic [9:0] dac_code,
	output logic sample_hold,
	output logic converter_power,
	output logic [15:0] pin_level
);
	logic speed_ff; // Converter clock speed select
	logic converter_enable_ff; // Converter on
	logic [3:0] input_selector_ff; // Selected input
	logic done_ff; // Conversion complete flag
	logic [9:0] result_ff; // Last conversion result
	logic [15:0] pin_level_ff; // Digital pin levels
	logic [31:0] prdata_ff; // Read data
	logic wr_en; // Write accepted
	logic rd_en; // Read accepted
	logic csr_wr; // Write to control/status
	logic sel_change; // Selector rewritten
	logic tick; // Converter clock enable
	logic conv_done; // Conversion completes
	logic [9:0] conv_result; // Completed code
	logic [7:0] csr_rd; // Control/status read image

	// Access phase always completes in its first cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign csr_wr = wr_en && (paddr == SADC_ADDR_CSR);
	// Any selector write restarts the conversion
	assign sel_change = csr_wr;

	// Unmapped address answers with an error
	always_comb begin
		pslverr = psel && penable && (paddr != SADC_ADDR_CSR)
			&& (paddr != SADC_ADDR_UPPER) && (paddr != SADC_ADDR_LOWER);
	end

	// Converter clock divider
	sadc_clkdiv sadc_clkdiv_inst (
		.clk(clk),
		.rst_n(rst_n),
		.run(converter_enable_ff),
		.fast(speed_ff),
		.tick(tick)
	);

	// Successive approximation sequencer
	sadc_sar sadc_sar_inst (
		.clk(clk),
		.rst_n(rst_n),
		.run(converter_enable_ff),
		.restart(sel_change),
		.tick(tick),
		.cmp_high(cmp_high),
		.sample(sample_hold),
		.trial(dac_code),
		.done(conv_done),
		.result(conv_result)
	);

	// Control bits written by software
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_ff <= 1'b0;
			converter_enable_ff <= 1'b0;
			input_selector_ff <= 4'h0;
		end else if (csr_wr) begin
			speed_ff <= pwdata[SADC_CSR_SPEED_BIT];
			converter_enable_ff <= pwdata[SADC_CSR_EN_BIT];
			input_selector_ff <= pwdata[SADC_CSR_SEL_LSB +: SADC_CSR_SEL_W];
		end
	end

	// Result store: direct overwrite, no pairing latch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_ff <= SADC_RES_RST;
		end else if (conv_done) begin
			result_ff <= conv_result;
		end
	end

	// Done flag: completion wins over a clearing access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else if (conv_done) begin
			done_ff <= 1'b1;
		end else if (csr_wr) begin
			done_ff <= 1'b0;
		end else if (rd_en && (paddr == SADC_ADDR_UPPER)) begin
			done_ff <= 1'b0;
		end
	end

	// Digital path of analog pins keeps working
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_level_ff <= 16'h0000;
		end else begin
			pin_level_ff <= analog_pin_digital;
		end
	end

	// Control/status read image
	always_comb begin
		csr_rd = SADC_CSR_RST;
		csr_rd[SADC_CSR_DONE_BIT] = done_ff;
		csr_rd[SADC_CSR_SPEED_BIT] = speed_ff;
		csr_rd[SADC_CSR_EN_BIT] = converter_enable_ff;
		csr_rd[SADC_CSR_SEL_LSB +: SADC_CSR_SEL_W] = input_selector_ff;
	end

	// Read data registered in the setup cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_ff <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				SADC_ADDR_CSR: begin
					prdata_ff <= {24'h000000, csr_rd};
				end
				SADC_ADDR_UPPER: begin
					prdata_ff <= {24'h000000, result_ff[9:2]};
				end
				SADC_ADDR_LOWER: begin
					prdata_ff <= {30'h00000000, result_ff[1:0]};
				end
				default: begin
					prdata_ff <= 32'h00000000;
				end
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign input_selector = input_selector_ff;
	assign converter_power = converter_enable_ff;
	assign pin_level = pin_level_ff;

	// Conversion time: 12 ticks from start to done
	logic [5:0] cyc_ff; // Clocks since last done or restart
	always_ff @(posedge clk) begin
		if (!rst_n || conv_done || sel_change || !converter_enable_ff) begin
			cyc_ff <= 6'h00;
		end else if (cyc_ff != 6'h3F) begin
			cyc_ff <= cyc_ff + 6'h01;
		end
	end

	// Completion raises the flag
	done_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done
		|=> done_ff)
		else $error("done flag not set");

	// Upper read clears the flag
	upper_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && paddr == SADC_ADDR_UPPER && !conv_done)
		|=> !done_ff)
		else $error("upper read left done set");

	// Control write clears the flag
	csr_wr_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
		(csr_wr && !conv_done)
		|=> !done_ff)
		else $error("write left done set");

	// Completed code lands in the result store
	result_stored_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done
		|=> result_ff == $past(conv_result))
		else $error("result lost");

	// No completion while switched off
	off_no_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		!converter_enable_ff
		|-> !conv_done)
		else $error("done while off");

	// Restart suppresses completion for a while
	restart_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
		sel_change
		|=> !conv_done [*8])
		else $error("no abort on selector");

	// Eleven ticks of two clocks at the fastest
	conv_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_done
		|-> cyc_ff >= 6'h15)
		else $error("conversion too short");

	// Fast converter clock ticks every second clock
	fast_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && speed_ff && converter_enable_ff && !csr_wr) ##1 !csr_wr
		|-> !tick ##1 tick)
		else $error("divide by two broken");

	// Lower result upper bits read zero
	lower_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && paddr == SADC_ADDR_LOWER)
		|-> prdata[31:2] == 30'h00000000)
		else $error("lower upper bits set");

	// Selector follows the written field
	sel_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		csr_wr
		|=> input_selector == $past(pwdata[3:0]))
		else $error("selector");

	// Slow converter clock ticks every fourth clock
	slow_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && !speed_ff && converter_enable_ff && !csr_wr) ##1 (!csr_wr) [*3]
		|-> !tick ##1 tick)
		else $error("divide by four broken");

	// Upper read image is result bits 9:2
	upper_image_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == SADC_ADDR_UPPER)
		|=> prdata == {24'h000000, $past(result_ff[9:2])})
		else $error("upper image wrong");

	// Lower read image is result bits 1:0
	lower_image_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == SADC_ADDR_LOWER)
		|=> prdata == {30'h00000000, $past(result_ff[1:0])})
		else $error("lower image wrong");

	// Status image shows the flag, reserved bit zero
	csr_image_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == SADC_ADDR_CSR)
		|=> (prdata[31:8] == 24'h000000 && !prdata[4] && prdata[7] == $past(done_ff)))
		else $error("status image wrong");

	// Flag stays up until a clearing access
	done_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
		(done_ff && !csr_wr && !(rd_en && paddr == SADC_ADDR_UPPER))
		|=> done_ff)
		else $error("done flag dropped");

	// Flag rises only on a completion
	done_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(done_ff)
		|-> $past(conv_done))
		else $error("done without completion");

	// Result changes only on a completion
	result_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
		!conv_done
		|=> $stable(result_ff))
		else $error("result changed alone");

	// Read data stands until the next read setup
	prdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(psel && !penable && !pwrite)
		|=> $stable(prdata))
		else $error("read data moved");

	// Selector changes only by a control write
	sel_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!csr_wr
		|=> $stable(input_selector))
		else $error("selector moved");

	// Enable bit follows the written value
	en_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		csr_wr
		|=> converter_power == $past(pwdata[SADC_CSR_EN_BIT]))
		else $error("enable not written");

	// Speed bit follows the written value
	speed_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		csr_wr
		|=> speed_ff == $past(pwdata[SADC_CSR_SPEED_BIT]))
		else $error("speed not written");

	// Sequencer parked while switched off
	off_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!converter_enable_ff && !$past(converter_enable_ff))
		|-> (!sample_hold && dac_code == 10'h000))
		else $error("sequencer running while off");

	// Restart parks the sequencer
	restart_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		sel_change
		|=> (!sample_hold && dac_code == 10'h000))
		else $error("sequencer not restarted");

	// First trial after sampling is the MSB alone
	msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sample_hold && tick && !sel_change)
		|=> dac_code == 10'h200)
		else $error("first trial not MSB");

	// Pin levels follow one clock later
	pin_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1
		|=> pin_level == $past(analog_pin_digital))
		else $error("pin level lost");

	// Control/status and upper result places answer without error
	err_known_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable && (paddr == SADC_ADDR_CSR || paddr == SADC_ADDR_UPPER))
		|-> !pslverr)
		else $error("error on mapped place");

	// Far places answer with an error
	err_other_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable && paddr[11:4] != 8'h00)
		|-> pslverr)
		else $error("no error on unmapped place");

	// Access phase never waits
	pready_a: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable)
		|-> pready)
		else $error("access phase stalled");

	// One conversion completes
	conv_c: cover property (@(posedge clk) conv_done);
	// Back-to-back conversions
	two_conv_c: cover property (@(posedge clk) conv_done ##[1:100] conv_done);
	// Restart within twenty clocks after sampling
	abort_c: cover property (@(posedge clk) sample_hold ##[1:20] sel_change);
	// Upper read after completion
	upper_rd_c: cover property (@(posedge clk) done_ff ##1 (rd_en && paddr == SADC_ADDR_UPPER));
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import sadc_pkg::*;
;
	logic clk = 1'b0; // Bus clock
	logic rst_n = 1'b0; // Synchronous reset
	logic psel = 1'b0; // Bus select
	logic penable = 1'b0; // Bus access phase
	logic pwrite = 1'b0; // Bus direction
	logic [11:0] paddr = 12'h000; // Bus address
	logic [31:0] pwdata = 32'h00000000; // Bus write data
	logic cmp_high = 1'b0; // Comparator answer
	logic [15:0] analog_pin_digital = 16'h0000; // Pin logic levels
	logic [31:0] prdata; // Bus read data
	logic pready; // Bus ready
	logic pslverr; // Bus error
	logic [3:0] input_selector; // Mux select
	logic [9:0] dac_code; // Trial code
	logic sample_hold; // Sampling strobe
	logic converter_power; // Converter on
	logic [15:0] pin_level; // Pin levels seen
	logic [10:0] vin = 11'h000; // Analog input, above 3FF is over range
	logic [31:0] rd; // Last read data
	logic er; // Last error flag
	logic [9:0] exp_res; // Expected result
	logic [9:0] prev_res; // Previous result
	logic [9:0] got_res; // Result read back
	logic seen; // Sampling seen while off
	logic [3:0] ch; // Selector under test
	int per; // Measured conversion period
	int fails = 0; // Mismatch count
	int n_checks = 0; // Comparison count
	localparam logic [10:0] VTBL [5] = '{11'h000, 11'h155, 11'h2A5, 11'h3FF, 11'h7FF};

	// Free running clock
	always #10 clk = ~clk;

	// Comparator: input at or above trial code
	always @(posedge clk) begin
		cmp_high <= (vin >= {1'b0, dac_code});
	end

	sadc_top sadc_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_high(cmp_high), .analog_pin_digital(analog_pin_digital),
		.input_selector(input_selector), .dac_code(dac_code), .sample_hold(sample_hold),
		.converter_power(converter_power), .pin_level(pin_level));

	// Verdict and end of run
	task finish_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Word compare
	task chk_data(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Flag compare
	task chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	// One bus transfer, entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Poll the done flag, bounded
	task wait_done();
		int k;
		k = 0;
		do begin
			apb(1'b0, SADC_ADDR_CSR, 32'h0);
			k++;
		end while (rd[7] !== 1'b1 && k < 60);
		chk_bit(rd[7], 1'b1);
	endtask

	// Clocks between two falls of the sampling strobe
	task period(output int p);
		int k;
		for (k = 0; k < 200 && sample_hold !== 1'b1; k++) @(negedge clk);
		for (k = 0; k < 200 && sample_hold === 1'b1; k++) @(negedge clk);
		for (p = 0; p < 200 && sample_hold !== 1'b1; p++) @(negedge clk);
		for (; p < 400 && sample_hold === 1'b1; p++) @(negedge clk);
		@(posedge clk);
	endtask

	// Watchdog, far beyond the expected run
	initial begin
		#400000;
		fails++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, SADC_ADDR_CSR, 32'h0);
		chk_data(rd, 32'h00000000);
		apb(1'b0, SADC_ADDR_UPPER, 32'h0);
		chk_data(rd, 32'h00000000);
		apb(1'b0, SADC_ADDR_LOWER, 32'h0);
		chk_data(rd, 32'h00000000);
		chk_bit(converter_power, 1'b0);
		// Unmapped place refuses
		apb(1'b0, 12'h00C, 32'h0);
		chk_bit(er, 1'b1);
		chk_data(rd, 32'h00000000);
		// Enable at both speeds, measure the continuous period
		apb(1'b1, SADC_ADDR_CSR, 32'h00000025);
		chk_bit(converter_power, 1'b1);
		chk_data({28'h0, input_selector}, 32'h00000005);
		period(per);
		chk_data(32'(per), 32'h0000002C);
		apb(1'b1, SADC_ADDR_CSR, 32'h00000065);
		period(per);
		chk_data(32'(per), 32'h00000016);
		// Input sweep: restart on write, result split, done handling
		for (int i = 0; i < 5; i++) begin
			ch = 4'(i * 3);
			wait_done();
			vin <= VTBL[i];
			apb(1'b1, SADC_ADDR_CSR, {24'h0, 4'h6, ch});
			apb(1'b0, SADC_ADDR_CSR, 32'h0);
			chk_data(rd, {24'h0, 4'h6, ch});
			chk_data({28'h0, input_selector}, {28'h0, ch});
			wait_done();
			exp_res = (VTBL[i] > 11'h3FF) ? 10'h3FF : VTBL[i][9:0];
			apb(1'b0, SADC_ADDR_LOWER, 32'h0);
			chk_data(rd, {30'h0, exp_res[1:0]});
			got_res[1:0] = rd[1:0];
			apb(1'b0, SADC_ADDR_UPPER, 32'h0);
			chk_data(rd, {24'h0, exp_res[9:2]});
			got_res[9:2] = rd[7:0];
			apb(1'b0, SADC_ADDR_CSR, 32'h0);
			chk_bit(rd[7], 1'b0);
			if (i > 0) chk_bit(got_res >= prev_res, 1'b1);
			prev_res = got_res;
		end
		// Result place is read only
		apb(1'b1, SADC_ADDR_UPPER, 32'h00000000);
		apb(1'b0, SADC_ADDR_UPPER, 32'h0);
		chk_data(rd, 32'h000000FF);
		// Disable stops conversion, keeps result
		apb(1'b1, SADC_ADDR_CSR, 32'h00000000);
		chk_bit(converter_power, 1'b0);
		seen = 1'b0;
		repeat (60) begin
			@(negedge clk);
			seen = seen | sample_hold;
		end
		chk_bit(seen, 1'b0);
		@(posedge clk);
		apb(1'b0, SADC_ADDR_CSR, 32'h0);
		chk_data(rd, 32'h00000000);
		apb(1'b0, SADC_ADDR_UPPER, 32'h0);
		chk_data(rd, 32'h000000FF);
		// Digital path of analog pins
		analog_pin_digital <= 16'hA5C3;
		@(posedge clk);
		@(negedge clk);
		chk_data({16'h0, pin_level}, 32'h0000A5C3);
		finish_test();
	end
endmodule
